// File: unv_pkg.sv
// Package: constants, register map, states and carriers of the NVM sequencer
package unv_pkg;

  // ****************************************************************
  // Sizes and limits
  // ****************************************************************
  localparam int USER_STORAGE_BITS = 112;
  localparam int STAGE_WORDS       = 7;    // 16-bit words of user data
  localparam int WORD_W            = 16;
  localparam int CNT_W             = 8;
  localparam logic [7:0] MAX_WRITE_CYCLES = 8'h20;
  localparam int TRIM_W            = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ          = 100_000_000;
  localparam int OP_DURATION_MS  = 10;
  localparam int OP_DURATION_CYC = (CLK_HZ / 1000) * OP_DURATION_MS;
  localparam int OP_RUN_CYC      = 16;     // default run length of an op

  // ****************************************************************
  // Register offsets (word addresses on the register port)
  // ****************************************************************
  localparam logic [7:0] ADR_STAGE0   = 8'h00; // staging 0..6 at 00..06
  localparam logic [7:0] ADR_READ0    = 8'h08; // readback 0..6 at 08..0e
  localparam logic [7:0] ADR_CNTR     = 8'h10;
  localparam logic [7:0] ADR_CTRL     = 8'h11;
  localparam logic [7:0] ADR_KEY      = 8'h12;
  localparam logic [7:0] ADR_STATUS   = 8'h13;
  localparam logic [7:0] ADR_TRIM     = 8'h14;

  // ****************************************************************
  // Field positions and keys
  // ****************************************************************
  localparam int CTRL_OPSEL_LSB   = 0;     // op_select [1:0]
  localparam int CTRL_ARM_BIT     = 2;     // program_arm
  localparam int CTRL_RELOAD_BIT  = 3;     // reload trigger
  localparam int ST_BUSY_BIT      = 0;     // op_in_progress_flag
  localparam int ST_CRC_BIT       = 1;     // user CRC fault flag
  localparam int ST_LOCK_BIT      = 2;     // write lock
  localparam int ST_KEY1_BIT      = 3;     // first key seen
  localparam logic [19:0] UNLOCK_KEY1 = 20'h1572f;
  localparam logic [19:0] UNLOCK_KEY2 = 20'h1602f;
  localparam logic [1:0]  OP_ERASE    = 2'h2;
  localparam logic [1:0]  OP_WRITE    = 2'h3;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ERASE, ST_WRITE, ST_READ, ST_READ_WAIT
  } unv_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } unv_bus_s;

endpackage

// File: unv_mem.sv
// Nonvolatile array model: user words plus counter word, registered read
`timescale 1ns/10ps
module unv_mem #(
  parameter int WORDS = 8,
  parameter int W     = 16
) (
  // Clock
  input  wire logic                     core_clk,
  // Access
  input  wire logic                     we,
  input  wire logic [$clog2(WORDS)-1:0] waddr,
  input  wire logic [W-1:0]             wdata,
  input  wire logic                     clr,
  input  wire logic [$clog2(WORDS)-1:0] raddr,
  output logic      [W-1:0]             rdata
);

  logic [W-1:0] mem_reg [WORDS];

  // Erase clears everything; programming can only add ones
  always_ff @(posedge core_clk) begin
    if (clr) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (we) begin
      mem_reg[waddr] <= mem_reg[waddr] | wdata;
    end
    rdata <= mem_reg[raddr];
  end

endmodule

// File: unv_seq.sv
// NVM access sequencer: registers, unlock keys, erase/write/read engine
`timescale 1ns/10ps
module unv_seq
  import unv_pkg::*;
#(
  parameter int OP_CYCLES = unv_pkg::OP_RUN_CYC
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Register port
  input  wire unv_pkg::unv_bus_s bus,
  output logic [31:0]            rdata,
  // Status
  output logic                   op_in_progress_flag,
  output logic                   crc_fault
);
  import unv_pkg::*;

  localparam int MW = STAGE_WORDS + 1;     // user words plus counter
  localparam int AW = $clog2(MW);
  localparam int TW = $clog2(OP_DURATION_CYC + 1);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (OP_CYCLES < MW + 2 || OP_CYCLES > OP_DURATION_CYC) begin : g_chk
    $error("OP_CYCLES must fit the array walk and 10 ms");
  end
  if (STAGE_WORDS * WORD_W != USER_STORAGE_BITS) begin : g_chk2
    $error("staging does not cover user storage");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    unv_state_e                           st;
    logic [STAGE_WORDS-1:0][WORD_W-1:0]   stage;
    logic [STAGE_WORDS-1:0][WORD_W-1:0]   readback;
    logic [CNT_W-1:0]                     cntr;
    logic [TRIM_W-1:0]                    trim;
    logic [1:0]                           opsel;
    logic                                 arm;
    logic                                 reload;
    logic                                 key1;
    logic                                 busy;
    logic                                 crc;
    logic                                 lock;
    logic [TW-1:0]                        timer;
    logic [WORD_W-1:0]                    crc_acc;
    logic [31:0]                          rdata;
  } unv_regs_s;

  unv_regs_s r_reg;
  unv_regs_s r_next;

  // Array port signals
  logic              mem_we;
  logic [AW-1:0]     mem_waddr;
  logic [WORD_W-1:0] mem_wdata;
  logic              mem_clr;
  logic [AW-1:0]     mem_raddr;
  logic [WORD_W-1:0] mem_rdata;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Index of a word within a 7-word window, or all ones if outside
  function automatic logic [3:0] word_sel(input logic [7:0] a,
                                          input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d < 8'(STAGE_WORDS)) begin
      word_sel = d[3:0];
    end else begin
      word_sel = 4'hf;
    end
  endfunction

  // Simple rotate-xor signature over the written and the downloaded words
  function automatic logic [WORD_W-1:0] sig_step(
      input logic [WORD_W-1:0] acc, input logic [WORD_W-1:0] w);
    sig_step = {acc[WORD_W-2:0], acc[WORD_W-1]} ^ w;
  endfunction

  // ****************************************************************
  // Nonvolatile array
  // ****************************************************************
  unv_mem #(.WORDS(MW), .W(WORD_W)) u_mem (
    .core_clk (core_clk),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .clr      (mem_clr),
    .raddr    (mem_raddr),
    .rdata    (mem_rdata)
  );

  // Array word MW-1 holds the counter; words 0..6 the user data
  // Trim lives in a separate sector that only a read touches
  localparam logic [AW-1:0] CNT_IDX   = AW'(MW - 1);
  // Counter word: count in the low byte, data signature above it
  localparam logic [TRIM_W-1:0] TRIM_SECTOR = 16'h5a5a; // arbitrary value

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [3:0] ws;
    logic       start;
    ws = 4'hf;
    start = 1'b0;
    r_next = r_reg;
    r_next.rdata = '0;
    mem_we = 1'b0;
    mem_clr = 1'b0;
    mem_waddr = '0;
    mem_raddr = '0;
    mem_wdata = '0;

    // Register writes
    if (bus.wr) begin
      ws = word_sel(bus.addr, ADR_STAGE0);
      if (ws != 4'hf) begin
        r_next.stage[ws[2:0]] = bus.wdata[WORD_W-1:0];
      end
      if (bus.addr == ADR_CTRL) begin
        r_next.opsel  = bus.wdata[CTRL_OPSEL_LSB +: 2];
        r_next.arm    = bus.wdata[CTRL_ARM_BIT];
        r_next.reload = bus.wdata[CTRL_RELOAD_BIT];
        // Any change of the arm setup drops a half-entered key
        r_next.key1 = 1'b0;
      end
      if (bus.addr == ADR_KEY) begin
        if (bus.wdata[19:0] == UNLOCK_KEY1) begin
          r_next.key1 = 1'b1;
        end else if (r_reg.key1 && bus.wdata[19:0] == UNLOCK_KEY2) begin
          r_next.key1 = 1'b0;
          start = 1'b1;
        end else begin
          r_next.key1 = 1'b0;
        end
      end
    end

    // Register reads; data stand in the following cycle
    if (bus.rd) begin
      ws = word_sel(bus.addr, ADR_STAGE0);
      if (ws != 4'hf) begin
        r_next.rdata = 32'(r_reg.stage[ws[2:0]]);
      end
      ws = word_sel(bus.addr, ADR_READ0);
      if (ws != 4'hf) begin
        r_next.rdata = 32'(r_reg.readback[ws[2:0]]);
      end
      case (bus.addr)
        ADR_CNTR: r_next.rdata = 32'(r_reg.cntr);
        ADR_CTRL: r_next.rdata = 32'({r_reg.reload, r_reg.arm,
                                      r_reg.opsel});
        ADR_STATUS: r_next.rdata = 32'({r_reg.key1, r_reg.lock,
                                        r_reg.crc, r_reg.busy});
        ADR_TRIM: r_next.rdata = 32'(r_reg.trim);
        default: ;
      endcase
    end

    // Sequencer
    case (r_reg.st)
      ST_IDLE: begin
        r_next.timer = '0;
        r_next.crc_acc = '0;
        if (start && r_reg.arm && !r_reg.lock &&
            r_reg.opsel == OP_ERASE) begin
          r_next.st = ST_ERASE;
          r_next.busy = 1'b1;
        end else if (start && r_reg.arm && !r_reg.lock &&
                     r_reg.cntr < MAX_WRITE_CYCLES &&
                     r_reg.opsel == OP_WRITE) begin
          r_next.st = ST_WRITE;
          r_next.busy = 1'b1;
        end else if (r_reg.reload) begin
          // Download runs without the busy flag
          r_next.st = ST_READ;
        end
      end
      ST_ERASE: begin
        // The whole array is cleared, counter word included; trim is kept
        mem_clr = (r_reg.timer == '0);
        r_next.timer = r_reg.timer + TW'(1);
        if (r_reg.timer == TW'(OP_CYCLES - 1)) begin
          r_next.st = ST_IDLE;
          r_next.busy = 1'b0;
        end
      end
      ST_WRITE: begin
        // Staging words, then counter register plus one
        if (r_reg.timer < TW'(MW)) begin
          mem_we = 1'b1;
          mem_waddr = AW'(r_reg.timer);
          if (AW'(r_reg.timer) == CNT_IDX) begin
            // Signature rides above the count for the download check
            mem_wdata = {r_reg.crc_acc[WORD_W-CNT_W-1:0],
                         r_reg.cntr + CNT_W'(1)};
          end else begin
            mem_wdata = r_reg.stage[AW'(r_reg.timer)];
            r_next.crc_acc = sig_step(r_reg.crc_acc,
                                      r_reg.stage[AW'(r_reg.timer)]);
          end
        end
        r_next.timer = r_reg.timer + TW'(1);
        if (r_reg.timer == TW'(OP_CYCLES - 1)) begin
          r_next.st = ST_IDLE;
          r_next.busy = 1'b0;
          // Counter register follows only on next download
        end
      end
      ST_READ: begin
        // Walk the array; data appear one cycle after address
        mem_raddr = AW'(r_reg.timer);
        if (r_reg.timer != '0 && r_reg.timer <= TW'(MW)) begin
          if (AW'(r_reg.timer - TW'(1)) == CNT_IDX) begin
            r_next.cntr = mem_rdata[CNT_W-1:0];
            // Stored signature against the one just computed
            r_next.crc = mem_rdata[WORD_W-1:CNT_W] !=
                         r_reg.crc_acc[WORD_W-CNT_W-1:0];
            if (mem_rdata[CNT_W-1:0] > MAX_WRITE_CYCLES) begin
              r_next.lock = 1'b1;
            end
          end else begin
            r_next.readback[AW'(r_reg.timer - TW'(1))] = mem_rdata;
            r_next.crc_acc = sig_step(r_reg.crc_acc, mem_rdata);
          end
        end
        r_next.timer = r_reg.timer + TW'(1);
        if (r_reg.timer == TW'(MW)) begin
          r_next.trim = TRIM_SECTOR;
          r_next.st = ST_READ_WAIT;
        end
      end
      ST_READ_WAIT: begin
        // Fault flag holds until the next download; reads end here,
        // well inside 10 ms
        if (!r_reg.reload) begin
          r_next.st = ST_IDLE;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.rdata;
  assign op_in_progress_flag = r_reg.busy;
  assign crc_fault = r_reg.crc;

endmodule

// File: unv_seq_chk.sv
// Checker: port-level assertions for the NVM sequencer, with its bind
`timescale 1ns/10ps
module unv_chk
  import unv_pkg::*;
#(
  parameter int OP_CYCLES = 16
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // Register port and status
  input wire unv_pkg::unv_bus_s bus,
  input wire logic [31:0]       rdata,
  input wire logic              op_in_progress_flag,
  input wire logic              crc_fault
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ****************************************************************
  // Helper state: key progress, armed op, busy run length
  // ****************************************************************
  logic        key1_reg;
  logic        arm_reg;
  logic        reload_reg;
  logic [1:0]  op_reg;
  logic [31:0] run_reg;
  wire kw = bus.wr && bus.addr == ADR_KEY;
  wire cw = bus.wr && bus.addr == ADR_CTRL;
  wire go = kw && key1_reg && bus.wdata[19:0] == UNLOCK_KEY2 && arm_reg;
  // A control write or any other key write drops the first key
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      key1_reg   <= 1'b0;
      arm_reg    <= 1'b0;
      reload_reg <= 1'b0;
      op_reg     <= 2'h0;
      run_reg    <= 32'h0;
    end else begin
      key1_reg <= kw ? bus.wdata[19:0] == UNLOCK_KEY1 : key1_reg && !cw;
      arm_reg    <= cw ? bus.wdata[CTRL_ARM_BIT] : arm_reg;
      reload_reg <= cw ? bus.wdata[CTRL_RELOAD_BIT] : reload_reg;
      op_reg     <= cw ? bus.wdata[1:0] : op_reg;
      run_reg    <= op_in_progress_flag ? run_reg + 32'h1 : 32'h0;
    end
  end
  busy_start_a: assert property (
    $rose(op_in_progress_flag) |-> $past(go))
    else $error("busy rose without the key pair");
  erase_go_a: assert property (
    go && op_reg == OP_ERASE && !reload_reg && !op_in_progress_flag
    |=> op_in_progress_flag)
    else $error("armed erase did not start");
  busy_max_a: assert property (
    op_in_progress_flag |-> run_reg < OP_CYCLES)
    else $error("busy ran too long");
  busy_len_a: assert property (
    $fell(op_in_progress_flag) |-> run_reg == OP_CYCLES)
    else $error("busy run length wrong");
  read_quiet_a: assert property (cw && bus.wdata[CTRL_RELOAD_BIT]
    && !op_in_progress_flag |=> !op_in_progress_flag [*8])
    else $error("busy raised by a download");
  status_busy_a: assert property (
    $past(bus.rd && bus.addr == ADR_STATUS)
    |-> rdata[ST_BUSY_BIT] == $past(op_in_progress_flag))
    else $error("status busy bit differs from flag");
  crc_hold_a: assert property (
    op_in_progress_flag |-> $stable(crc_fault))
    else $error("crc fault moved during erase or write");
  wrong_key_a: assert property (
    kw && bus.wdata[19:0] != UNLOCK_KEY2 && !op_in_progress_flag
    |=> !op_in_progress_flag)
    else $error("busy started on a non-final key");
endmodule
bind unv_seq unv_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .op_in_progress_flag(op_in_progress_flag), .crc_fault(crc_fault));

// File: unv_host.sv
// Host model: register-port master and NVM operation procedures
`timescale 1ns/10ps
module unv_host
  import unv_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Register port toward the device
  output unv_pkg::unv_bus_s bus,
  input  wire logic [31:0] rdata,
  input  wire logic        op_in_progress_flag
);
  initial bus = '0;
  // One write cycle, strobe dropped on the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus <= '0;
  endtask
  // One read cycle; data stand only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
    d = rdata;
  endtask
  // Arm, send keys, poll busy down (bounded), disarm
  task automatic op(input logic [1:0] o, input logic [19:0] k1,
                    output logic seen, output logic ok);
    logic [31:0] s;
    wr(ADR_CTRL, {29'h0, 1'b1, o});
    wr(ADR_KEY, {12'h0, k1});
    wr(ADR_KEY, {12'h0, UNLOCK_KEY2});
    @(negedge core_clk);
    seen = op_in_progress_flag;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      rd(ADR_STATUS, s);
      ok = s[ST_BUSY_BIT] === 1'b0;
    end
    wr(ADR_CTRL, 32'h0);
  endtask
  // Download: trigger high, wait the nine-cycle run, trigger low
  task automatic reload();
    wr(ADR_CTRL, 32'h8);
    repeat (10) @(posedge core_clk);
    wr(ADR_CTRL, 32'h0);
  endtask
endmodule

// File: user_nvm_access_sequencer_tb.sv
// Testbench: host model drives the sequencer against an integer model
`timescale 1ns/10ps
module user_nvm_access_sequencer_tb;
  import unv_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  unv_bus_s    bus;
  logic [31:0] rdata;
  logic        busy;
  logic        crc;
  int          fails = 0;
  int          num_checks = 0;
  integer      seed = 32'ha473;
  int          stage [7];
  int          mem [7];
  int          rb [7];
  int          cnt = 0;
  int          rcnt = 0;
  unv_seq #(.OP_CYCLES(16)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .bus(bus), .rdata(rdata), .op_in_progress_flag(busy), .crc_fault(crc));
  unv_host i_host (.core_clk(core_clk), .bus(bus), .rdata(rdata),
    .op_in_progress_flag(busy));
  always #5 core_clk = ~core_clk;
  // ****************************************************************
  // Comparison and verdict
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Readback words and counter against the last download
  task automatic sweep();
    logic [31:0] d;
    for (int i = 0; i < STAGE_WORDS; i++) begin
      i_host.rd(ADR_READ0 + 8'(i), d);
      chk("readback", d, 32'(rb[i]));
    end
    i_host.rd(ADR_CNTR, d);
    chk("counter", d, 32'(rcnt));
    chk("crc flag", {31'h0, crc}, 32'h0);
  endtask
  // Random staging data, confirmed by reading back
  task automatic fill();
    logic [31:0] d;
    for (int i = 0; i < STAGE_WORDS; i++) begin
      stage[i] = $random(seed) & 32'hffff;
      i_host.wr(ADR_STAGE0 + 8'(i), 32'(stage[i]));
    end
    for (int i = 0; i < STAGE_WORDS; i++) begin
      i_host.rd(ADR_STAGE0 + 8'(i), d);
      chk("staging", d, 32'(stage[i]));
    end
  endtask
  // Erase or write; model updates only when the op should start
  task automatic run(input logic [1:0] o, input logic [19:0] k);
    logic seen;
    logic ok;
    logic go;
    // Write limit is judged on the downloaded counter register
    go = k == UNLOCK_KEY1 && (o == OP_ERASE || rcnt < 32);
    i_host.op(o, k, seen, ok);
    chk("busy seen", {31'h0, seen}, {31'h0, go});
    chk("poll done", {31'h0, ok}, 32'h1);
    if (!ok) close_out();
    if (go && o == OP_ERASE) begin
      mem = '{default: 0};
      cnt = 0;
    end
    if (go && o == OP_WRITE) begin
      foreach (mem[i]) mem[i] |= stage[i];
      cnt |= rcnt + 1;
    end
    sweep();
  endtask
  // Download and compare everything, trim included
  task automatic load();
    logic [31:0] d;
    i_host.reload();
    rb = mem;
    rcnt = cnt;
    i_host.rd(ADR_TRIM, d);
    chk("trim", d, 32'h5a5a);
    sweep();
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    close_out();
  end
  // Main sequence: erase, write, read; a second round; bad keys; limit
  initial begin
    logic [31:0] d;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    sweep();
    i_host.wr(8'h07, 32'hffff);
    i_host.rd(8'h07, d);
    chk("unmapped", d, 32'h0);
    fill();
    run(OP_ERASE, UNLOCK_KEY1);
    run(OP_WRITE, UNLOCK_KEY1);
    load();
    fill();
    run(OP_ERASE, UNLOCK_KEY1);
    run(OP_WRITE, UNLOCK_KEY1);
    load();
    run(OP_ERASE, UNLOCK_KEY2);
    run(OP_WRITE, 20'h0abcd);
    load();
    // Full erase-write-read cycles up to the write limit
    repeat (30) begin
      run(OP_ERASE, UNLOCK_KEY1);
      run(OP_WRITE, UNLOCK_KEY1);
      load();
    end
    // Saturated: this write is refused, reads still work
    run(OP_WRITE, UNLOCK_KEY1);
    // Download again; erase stays allowed, as lock needs a count above 32
    load();
    close_out();
  end
endmodule
